/* File: rtl/cardbus_socket_event_regs.sv */
// socket event, enable, live status and force registers of one card socket
`timescale 1ns/100ps
`default_nettype none
module cardbus_socket_event_regs (
  input  wire logic                                  SYS_CLK_I,
  input  wire logic                                  RESET_N_I,
  input  wire logic                                  CFG_BASE_WE_I,
  input  wire logic [socket_regs_pkg::DATA_W-1:0]    CFG_BASE_DATA_I,
  output var  logic [socket_regs_pkg::DATA_W-1:0]    CFG_BASE_O,
  input  wire logic                                  MEM_SEL_I,
  input  wire logic                                  MEM_WRITE_I,
  input  wire logic [socket_regs_pkg::DATA_W-1:0]    MEM_ADDR_I,
  input  wire logic [3:0]                            MEM_BE_I,
  input  wire logic [socket_regs_pkg::DATA_W-1:0]    MEM_WDATA_I,
  output var  logic [socket_regs_pkg::DATA_W-1:0]    MEM_RDATA_O,
  output var  logic                                  MEM_ACK_O,
  input  wire logic                                  DETECT_ONE_N_I,
  input  wire logic                                  DETECT_TWO_N_I,
  input  wire logic                                  STATUS_CHANGE_I,
  input  wire logic                                  SOCKET_POWERED_I,
  input  wire logic                                  CARD_IDENTIFYING_I,
  input  wire logic                                  CARD_RESET_I,
  input  wire logic                                  CARD_READY_I,
  input  wire logic                                  CARD_IS_CARDBUS_I,
  input  wire logic                                  CARD_IS_16BIT_I,
  input  wire logic                                  CARD_NOT_RECOGNISED_I,
  input  wire logic [socket_regs_pkg::CAPS_W-1:0]    CARD_VOLTAGE_CAPS_I,
  output var  logic [socket_regs_pkg::DATA_W-1:0]    CONTROL_O,
  output var  logic [socket_regs_pkg::DATA_W-1:0]    POWER_CTRL_O,
  output var  logic                                  STATUS_CHANGE_INTERRUPT_O
);
  import socket_regs_pkg::*;

  // ****************************************************************
  // slot sampling
  // ****************************************************************
  logic [SYNC_W-1:0] raw_pins;
  logic [SYNC_W-1:0] synced;
  logic              detect_one_status;
  logic              detect_two_status;

  assign raw_pins = {CARD_VOLTAGE_CAPS_I, CARD_NOT_RECOGNISED_I, CARD_IS_16BIT_I,
                     CARD_IS_CARDBUS_I, CARD_READY_I, CARD_RESET_I, CARD_IDENTIFYING_I,
                     SOCKET_POWERED_I, STATUS_CHANGE_I, DETECT_TWO_N_I, DETECT_ONE_N_I};

  socket_status_sync u_sync (
    .SYS_CLK_I    (SYS_CLK_I),
    .RESET_N_I    (RESET_N_I),
    .raw_i        (raw_pins),
    .synced_o     (synced),
    .detect_one_o (detect_one_status),
    .detect_two_o (detect_two_status)
  );

  logic status_change_level;
  logic socket_powered_status;
  logic identifying;
  logic card_reset;

  assign status_change_level   = synced[SYN_STATUS];
  assign socket_powered_status = synced[SYN_POWERED];
  assign identifying           = synced[SYN_IDENTIFYING];
  assign card_reset            = synced[SYN_CARD_RESET];

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic [DATA_W-1:0] base_reg;
  logic              hit;
  logic [OFF_W-1:0]  offset;
  logic [DATA_W-1:0] byte_mask;
  logic [DATA_W-1:0] wdata_masked;
  logic              wr_event;
  logic              wr_enable;
  logic              wr_force;
  logic              wr_control;
  logic              wr_power;

  // the 4 KB socket window is found through this socket's own base only
  assign hit          = MEM_SEL_I && (MEM_ADDR_I[DATA_W-1:OFF_W] == base_reg[DATA_W-1:OFF_W]);
  assign offset       = {MEM_ADDR_I[OFF_W-1:2], 2'h0};
  assign byte_mask    = {{8{MEM_BE_I[3]}}, {8{MEM_BE_I[2]}}, {8{MEM_BE_I[1]}}, {8{MEM_BE_I[0]}}};
  assign wdata_masked = MEM_WDATA_I & byte_mask;
  assign wr_event     = hit && MEM_WRITE_I && (offset == OFF_EVENT_FLAGS);
  assign wr_enable    = hit && MEM_WRITE_I && (offset == OFF_IRQ_ENABLES);
  assign wr_force     = hit && MEM_WRITE_I && (offset == OFF_EVENT_FORCE);
  assign wr_control   = hit && MEM_WRITE_I && (offset == OFF_CONTROL);
  assign wr_power     = hit && MEM_WRITE_I && (offset == OFF_POWER_CTRL);

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      base_reg <= BASE_RESET;
    end else if (CFG_BASE_WE_I) begin
      base_reg <= {CFG_BASE_DATA_I[DATA_W-1:OFF_W], {OFF_W{1'b0}}};
    end
  end

  assign CFG_BASE_O = base_reg;

  // ****************************************************************
  // change detection
  // ****************************************************************
  logic               prev_valid_reg;
  logic               prev_powered_reg;
  logic               prev_detect_one_reg;
  logic               prev_detect_two_reg;
  logic               prev_status_reg;
  logic               prev_card_reset_reg;
  logic               prev_identifying_reg;
  logic               card_present;
  logic               status_edge;
  logic               reset_release;
  logic [EVENT_W-1:0] hw_set;
  logic [EVENT_W-1:0] force_set;
  logic [EVENT_W-1:0] clear_req;

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      prev_valid_reg       <= 1'b0;
      prev_powered_reg     <= 1'b0;
      prev_detect_one_reg  <= 1'b1;
      prev_detect_two_reg  <= 1'b1;
      prev_status_reg      <= 1'b0;
      prev_card_reset_reg  <= 1'b0;
      prev_identifying_reg <= 1'b0;
    end else begin
      prev_valid_reg       <= 1'b1;
      prev_powered_reg     <= socket_powered_status;
      prev_detect_one_reg  <= detect_one_status;
      prev_detect_two_reg  <= detect_two_status;
      prev_status_reg      <= status_change_level;
      prev_card_reset_reg  <= card_reset;
      prev_identifying_reg <= identifying;
    end
  end

  logic [DATA_W-1:0] card_info_reg;

  assign card_present  = !detect_one_status && !detect_two_status;
  assign reset_release = prev_valid_reg && prev_card_reset_reg && !card_reset;
  // cardbus cards signal on the rising edge only, 16-bit cards on either
  assign status_edge   = card_info_reg[BIT_CARD_CARDBUS] ?
                         (status_change_level && !prev_status_reg) :
                         (status_change_level != prev_status_reg);

  always_comb begin
    hw_set = '0;
    if (prev_valid_reg) begin
      hw_set[BIT_POWER_CYCLE]   = socket_powered_status != prev_powered_reg;
      hw_set[BIT_DETECT_TWO]    = detect_two_status != prev_detect_two_reg;
      hw_set[BIT_DETECT_ONE]    = detect_one_status != prev_detect_one_reg;
      hw_set[BIT_STATUS_CHANGE] = status_edge;
    end
    // leaving card reset with the condition still standing raises it again
    if (reset_release) begin
      hw_set[BIT_STATUS_CHANGE] = hw_set[BIT_STATUS_CHANGE] | status_change_level;
      hw_set[BIT_DETECT_ONE]    = hw_set[BIT_DETECT_ONE] | !detect_one_status;
      hw_set[BIT_DETECT_TWO]    = hw_set[BIT_DETECT_TWO] | !detect_two_status;
    end
  end

  assign force_set = wr_force ? wdata_masked[EVENT_W-1:0] : '0;
  assign clear_req = wr_event ? wdata_masked[EVENT_W-1:0] : '0;

  // ****************************************************************
  // event flags and enables
  // ****************************************************************
  logic [EVENT_W-1:0] event_flags_reg;
  logic [EVENT_W-1:0] irq_enable_reg;
  logic [EVENT_W-1:0] enabled_events;

  // a set in the same cycle as its clear wins, so no event is lost;
  // enables are not consulted here
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      event_flags_reg <= EVENT_FLAGS_RESET[EVENT_W-1:0];
    end else begin
      event_flags_reg <= (event_flags_reg & ~clear_req) | hw_set | force_set;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      irq_enable_reg <= IRQ_ENABLE_RESET[EVENT_W-1:0];
    end else if (wr_enable) begin
      irq_enable_reg <= (irq_enable_reg & ~byte_mask[EVENT_W-1:0]) |
                        wdata_masked[EVENT_W-1:0];
    end
  end

  // reserved detect codes 01 and 10 are treated as disabled
  assign enabled_events[BIT_POWER_CYCLE]   = irq_enable_reg[BIT_POWER_CYCLE];
  assign enabled_events[BIT_DETECT_TWO]    =
    irq_enable_reg[BIT_DETECT_TWO:BIT_DETECT_ONE] == DETECT_MASK_ON;
  assign enabled_events[BIT_DETECT_ONE]    =
    irq_enable_reg[BIT_DETECT_TWO:BIT_DETECT_ONE] == DETECT_MASK_ON;
  assign enabled_events[BIT_STATUS_CHANGE] = irq_enable_reg[BIT_STATUS_CHANGE];

  // software must clear stale flags first, or enabling fires at once
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      STATUS_CHANGE_INTERRUPT_O <= 1'b0;
    end else begin
      STATUS_CHANGE_INTERRUPT_O <= |(event_flags_reg & enabled_events);
    end
  end

  // ****************************************************************
  // card information and force overlay
  // ****************************************************************
  logic              insertion_done;
  logic [DATA_W-1:0] forced_info_reg;
  logic [DATA_W-1:0] card_info_next;

  assign insertion_done = prev_identifying_reg && !identifying && card_present;

  always_comb begin
    card_info_next = '0;
    card_info_next[BIT_CAPS_LO +: CAPS_W] = synced[SYN_CAPS_LO +: CAPS_W];
    card_info_next[BIT_NOT_A_CARD]        = synced[SYN_NOT_A_CARD];
    card_info_next[BIT_CARD_CARDBUS]      = synced[SYN_CARDBUS];
    card_info_next[BIT_CARD_16BIT]        = synced[SYN_16BIT];
  end

  // forced card fields last until the next real interrogation replaces them
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      card_info_reg   <= '0;
      forced_info_reg <= '0;
    end else if (insertion_done) begin
      card_info_reg   <= card_info_next;
      forced_info_reg <= '0;
    end else if (wr_force) begin
      forced_info_reg <= forced_info_reg | (wdata_masked & FORCE_STICKY_MASK);
    end
  end

  logic [DATA_W-1:0] live_status;

  always_comb begin
    live_status = LIVE_SUPPLY_BITS | card_info_reg | forced_info_reg;
    live_status[BIT_READY_LEVEL]   = synced[SYN_READY];
    live_status[BIT_POWER_CYCLE]   = socket_powered_status;
    live_status[BIT_DETECT_TWO]    = detect_two_status;
    live_status[BIT_DETECT_ONE]    = detect_one_status;
    live_status[BIT_STATUS_CHANGE] = status_change_level;
  end

  // ****************************************************************
  // control and power registers
  // ****************************************************************
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      CONTROL_O    <= CONTROL_RESET;
      POWER_CTRL_O <= POWER_CTRL_RESET;
    end else begin
      if (wr_control) begin
        CONTROL_O <= (CONTROL_O & ~byte_mask) | wdata_masked;
      end
      if (wr_power) begin
        POWER_CTRL_O <= (POWER_CTRL_O & ~byte_mask) | wdata_masked;
      end
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  logic [DATA_W-1:0] read_mux;

  // unmapped offsets and the write-only force register read as zero
  always_comb begin
    case (offset)
      OFF_EVENT_FLAGS: read_mux = {{(DATA_W-EVENT_W){1'b0}}, event_flags_reg};
      OFF_IRQ_ENABLES: read_mux = {{(DATA_W-EVENT_W){1'b0}}, irq_enable_reg};
      OFF_LIVE_STATUS: read_mux = live_status;
      OFF_CONTROL:     read_mux = CONTROL_O;
      OFF_POWER_CTRL:  read_mux = POWER_CTRL_O;
      default:         read_mux = '0;
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      MEM_ACK_O   <= 1'b0;
      MEM_RDATA_O <= '0;
    end else begin
      MEM_ACK_O   <= hit;
      MEM_RDATA_O <= (hit && !MEM_WRITE_I) ? read_mux : '0;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESET_N_I);

  a_clear_one_flag: assert property (
    (wr_event && MEM_WDATA_I[0] && MEM_BE_I[0] && !hw_set[0] && !force_set[0])
    |=> !event_flags_reg[0])
    else $error("event flag 0 not cleared by write of one");

  a_force_sets_flag: assert property (
    (wr_force && MEM_BE_I[0] && MEM_WDATA_I[3]) |=> event_flags_reg[3])
    else $error("force write did not set event flag 3");

  a_power_event: assert property (
    (prev_valid_reg && socket_powered_status != $past(socket_powered_status))
    |=> event_flags_reg[BIT_POWER_CYCLE])
    else $error("powered change did not set flag 3");

  a_detect_event: assert property (
    $changed(detect_two_status) && prev_valid_reg && $past(prev_valid_reg)
    |=> event_flags_reg[BIT_DETECT_TWO])
    else $error("detect two change did not set flag 2");

  a_reserved_zero: assert property (
    (hit && !MEM_WRITE_I && offset == OFF_IRQ_ENABLES) |=> MEM_ACK_O && MEM_RDATA_O[31:4] == '0)
    else $error("enable register upper bits not zero");

  a_supply_bits: assert property (
    (hit && !MEM_WRITE_I && offset == OFF_LIVE_STATUS) |=> MEM_RDATA_O[29:28] == 2'h3)
    else $error("supply capability bits not set");

  a_irq_follows: assert property (
    ##1 STATUS_CHANGE_INTERRUPT_O == $past(|(event_flags_reg & enabled_events)))
    else $error("interrupt does not follow enabled flags");

  a_mask_gates_irq: assert property (
    (irq_enable_reg == 4'h2 && event_flags_reg == 4'h2) |=> !STATUS_CHANGE_INTERRUPT_O)
    else $error("reserved detect code raised interrupt");

  a_detect_hold: assert property (
    (identifying && $past(identifying)) |=> $stable(detect_one_status) && $stable(detect_two_status))
    else $error("detect status moved while identifying");

  c_insertion_irq: cover property (
    $rose(hw_set[BIT_DETECT_ONE]) ##[1:4] STATUS_CHANGE_INTERRUPT_O);
  c_force_then_clear: cover property (
    wr_force ##[1:8] wr_event ##1 event_flags_reg == 4'h0);
  c_card_info_latch: cover property (insertion_done);

endmodule
`default_nettype wire

/* File: rtl/socket_regs_pkg.sv */
// constants shared by the socket register block and its status sampler
package socket_regs_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned OFF_W    = 12;
  localparam int unsigned EVENT_W  = 4;
  localparam int unsigned CAPS_W   = 4;
  // pins sampled: detect one, detect two, status change, powered, identifying,
  // card reset, ready, cardbus type, 16-bit type, not-a-card, four voltage caps
  localparam int unsigned SYNC_W   = 14;

  // ****************************************************************
  // register offsets from the socket base
  // ****************************************************************
  localparam logic [OFF_W-1:0] OFF_EVENT_FLAGS  = 12'h000;
  localparam logic [OFF_W-1:0] OFF_IRQ_ENABLES  = 12'h004;
  localparam logic [OFF_W-1:0] OFF_LIVE_STATUS  = 12'h008;
  localparam logic [OFF_W-1:0] OFF_EVENT_FORCE  = 12'h00C;
  localparam logic [OFF_W-1:0] OFF_CONTROL      = 12'h010;
  localparam logic [OFF_W-1:0] OFF_POWER_CTRL   = 12'h020;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned BIT_STATUS_CHANGE = 0;
  localparam int unsigned BIT_DETECT_ONE    = 1;
  localparam int unsigned BIT_DETECT_TWO    = 2;
  localparam int unsigned BIT_POWER_CYCLE   = 3;
  localparam int unsigned BIT_CARD_16BIT    = 4;
  localparam int unsigned BIT_CARD_CARDBUS  = 5;
  localparam int unsigned BIT_READY_LEVEL   = 6;
  localparam int unsigned BIT_NOT_A_CARD    = 7;
  localparam int unsigned BIT_CAPS_LO       = 10;
  localparam int unsigned BIT_SUPPLY_5V     = 28;
  localparam int unsigned BIT_SUPPLY_3V     = 29;

  // sampler vector positions
  localparam int unsigned SYN_DETECT_ONE  = 0;
  localparam int unsigned SYN_DETECT_TWO  = 1;
  localparam int unsigned SYN_STATUS      = 2;
  localparam int unsigned SYN_POWERED     = 3;
  localparam int unsigned SYN_IDENTIFYING = 4;
  localparam int unsigned SYN_CARD_RESET  = 5;
  localparam int unsigned SYN_READY       = 6;
  localparam int unsigned SYN_CARDBUS     = 7;
  localparam int unsigned SYN_16BIT       = 8;
  localparam int unsigned SYN_NOT_A_CARD  = 9;
  localparam int unsigned SYN_CAPS_LO     = 10;

  // ****************************************************************
  // reset values and masks
  // ****************************************************************
  localparam logic [DATA_W-1:0]  EVENT_FLAGS_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0]  IRQ_ENABLE_RESET  = 32'h0000_0000;
  localparam logic [DATA_W-1:0]  CONTROL_RESET     = 32'h0000_0000;
  localparam logic [DATA_W-1:0]  POWER_CTRL_RESET  = 32'h0000_0000;
  localparam logic [DATA_W-1:0]  BASE_RESET        = 32'h0000_0000;
  localparam logic [DATA_W-1:0]  LIVE_SUPPLY_BITS  = 32'h3000_0000;
  // force bits that stick into the live status view (card info fields)
  localparam logic [DATA_W-1:0]  FORCE_STICKY_MASK = 32'h0000_3FB0;
  localparam logic [SYNC_W-1:0]  SYNC_RESET        = 14'h0003;
  localparam logic [1:0]         DETECT_MASK_ON    = 2'h3;

endpackage

/* File: rtl/socket_status_sync.sv */
// two-stage sampler for slot pins, with card-detect hold during identification
`timescale 1ns/100ps
`default_nettype none
module socket_status_sync (
  input  wire logic                                SYS_CLK_I,
  input  wire logic                                RESET_N_I,
  input  wire logic [socket_regs_pkg::SYNC_W-1:0]  raw_i,
  output var  logic [socket_regs_pkg::SYNC_W-1:0]  synced_o,
  output var  logic                                detect_one_o,
  output var  logic                                detect_two_o
);
  import socket_regs_pkg::*;

  logic [SYNC_W-1:0] stage1_reg;
  logic [SYNC_W-1:0] stage2_reg;

  // ****************************************************************
  // synchronisers
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
          stage1_reg[gi] <= SYNC_RESET[gi];
          stage2_reg[gi] <= SYNC_RESET[gi];
        end else begin
          stage1_reg[gi] <= raw_i[gi];
          stage2_reg[gi] <= stage1_reg[gi];
        end
      end
    end
  endgenerate

  assign synced_o = stage2_reg;

  // ****************************************************************
  // card-detect hold
  // ****************************************************************
  // the detect pins are driven by identification itself; freezing here
  // keeps those probe pulses out of both status and events
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      detect_one_o <= 1'b1;
      detect_two_o <= 1'b1;
    end else if (!stage2_reg[SYN_IDENTIFYING]) begin
      detect_one_o <= stage2_reg[SYN_DETECT_ONE];
      detect_two_o <= stage2_reg[SYN_DETECT_TWO];
    end
  end

endmodule
`default_nettype wire

/* File: testbench/slot_model.sv */
// slot-side model: a card socket behind a switched supply
`timescale 1ns/100ps
`default_nettype none
module slot_model (
  input  wire logic clk_i,
  input  wire logic power_on_i,
  input  wire logic status_i,
  input  wire logic card_in_i,
  output wire logic detect_n_o,
  output var  logic powered_o,
  output var  logic status_o
);
  // both detect pins sit at their pull-up level until a card pulls them low
  assign detect_n_o = !card_in_i;
  always @(posedge clk_i) {powered_o, status_o} <= {power_on_i, status_i};
endmodule
`default_nettype wire

/* File: testbench/test_cardbus_socket_event_regs.sv */
// self-checking bench for the socket event register block
`timescale 1ns/100ps
`default_nettype none
module test_cardbus_socket_event_regs;
  import socket_regs_pkg::*;
  logic clk = 0, rst_n = 0, sel = 0, wr = 0, pwr = 0, sts = 0, cfg_we = 0;
  logic det_n, pwr_q, sts_q, ack, irq;
  logic card = 0, cbus = 0, ident = 0, crst = 0;
  logic [5:0] misc = '0;
  logic [DATA_W-1:0] addr = '0, wd = '0, rdata, rd, base, ctl, pwc, d;
  logic [3:0] en [5] = '{4'h8, 4'h1, 4'h4, 4'h6, 4'h2};
  integer fails = 0, comparisons = 0, seed = 32'h270d, i;
  always #12.5 clk = ~clk;
  slot_model u_slot_model (.clk_i(clk), .power_on_i(pwr), .status_i(sts), .card_in_i(card),
    .detect_n_o(det_n), .powered_o(pwr_q), .status_o(sts_q));
  cardbus_socket_event_regs u_cardbus_socket_event_regs (.SYS_CLK_I(clk), .RESET_N_I(rst_n),
    .CFG_BASE_WE_I(cfg_we), .CFG_BASE_DATA_I(32'hABCD_E123), .CFG_BASE_O(base),
    .MEM_SEL_I(sel), .MEM_WRITE_I(wr), .MEM_ADDR_I(addr), .MEM_BE_I(4'hF), .MEM_WDATA_I(wd),
    .MEM_RDATA_O(rdata), .MEM_ACK_O(ack), .DETECT_ONE_N_I(det_n), .DETECT_TWO_N_I(det_n),
    .STATUS_CHANGE_I(sts_q), .SOCKET_POWERED_I(pwr_q), .CARD_IDENTIFYING_I(ident),
    .CARD_RESET_I(crst), .CARD_READY_I(misc[0]), .CARD_IS_CARDBUS_I(cbus),
    .CARD_IS_16BIT_I(!cbus), .CARD_NOT_RECOGNISED_I(misc[1]),
    .CARD_VOLTAGE_CAPS_I(misc[5:2]), .CONTROL_O(ctl), .POWER_CTRL_O(pwc),
    .STATUS_CHANGE_INTERRUPT_O(irq));
  function automatic logic want_irq(input logic [3:0] f, input logic [3:0] e);
    return |(f & {e[3], {2{e[2] & e[1]}}, e[0]});
  endfunction
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // pin changes need sync stages plus the detect hold before flags move
  task automatic settle;
    repeat (8) @(posedge clk);
    #1;
  endtask
  // ready, caps and not-a-card wander at random; none may ever reach the flags
  task automatic access(input logic w, input logic [OFF_W-1:0] off, input logic [DATA_W-1:0] v);
    @(posedge clk);
    {sel, wr, addr, wd} <= {1'b1, w, 20'hABCDE, off, v};
    misc <= 6'($random(seed));
    @(posedge clk);
    sel <= 1'b0;
    #1 rd = rdata;
    check({31'h0, ack}, 32'h1);
    if (ack !== 1'b1) give_verdict;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    cfg_we <= 1'b1;
    @(posedge clk);
    cfg_we <= 1'b0;
    settle;
    check(base, 32'hABCD_E000);
    @(posedge clk);
    {sel, addr} <= {1'b1, 32'h1234_5000};
    @(posedge clk);
    sel <= 1'b0;
    #1 check({31'h0, ack}, 32'h0);
    access(1'b0, OFF_EVENT_FLAGS, '0);
    check(rd, '0);
    access(1'b0, OFF_LIVE_STATUS, '0);
    check(rd & 32'hF000_000F, 32'h3000_0006);
    for (i = 0; i < 8; i++) begin
      d = $random(seed);
      access(1'b1, OFF_IRQ_ENABLES, d);
      access(1'b0, OFF_IRQ_ENABLES, '0);
      check(rd, d & 32'hF);
    end
    access(1'b1, OFF_IRQ_ENABLES, '0);
    access(1'b1, OFF_EVENT_FORCE, 32'h8F);
    access(1'b0, OFF_EVENT_FLAGS, '0);
    check(rd, 32'hF);
    for (i = 0; i < 5; i++) begin
      access(1'b1, OFF_IRQ_ENABLES, {28'h0, en[i]});
      settle;
      check({31'h0, irq}, {31'h0, want_irq(4'hF, en[i])});
    end
    access(1'b1, OFF_EVENT_FLAGS, 32'hD);
    access(1'b0, OFF_EVENT_FLAGS, '0);
    check(rd, 32'h2);
    access(1'b1, OFF_EVENT_FLAGS, 32'hF);
    access(1'b1, OFF_IRQ_ENABLES, 32'h8);
    @(posedge clk);
    {pwr, sts} <= 2'b11;
    settle;
    check({31'h0, irq}, 32'h1);
    access(1'b0, OFF_EVENT_FLAGS, '0);
    check(rd, 32'h9);
    access(1'b0, OFF_LIVE_STATUS, '0);
    check(rd & 32'hF000_008F, 32'h3000_008F);
    access(1'b1, OFF_EVENT_FLAGS, 32'h9);
    @(posedge clk);
    sts <= 1'b0;
    settle;
    access(1'b0, OFF_EVENT_FLAGS, '0);
    check(rd, 32'h1);
    // a cardbus card goes in, then identification probes the detect pins
    access(1'b1, OFF_EVENT_FLAGS, 32'hF);
    @(posedge clk);
    {card, cbus} <= 2'b11;
    settle;
    access(1'b0, OFF_EVENT_FLAGS, '0);
    check(rd, 32'h6);
    access(1'b1, OFF_EVENT_FLAGS, 32'h6);
    @(posedge clk);
    ident <= 1'b1;
    settle;
    @(posedge clk);
    card <= 1'b0;
    settle;
    access(1'b0, OFF_LIVE_STATUS, '0);
    check(rd & 32'h6, 32'h0);
    @(posedge clk);
    card <= 1'b1;
    settle;
    @(posedge clk);
    ident <= 1'b0;
    settle;
    access(1'b0, OFF_LIVE_STATUS, '0);
    check(rd & 32'h36, 32'h20);
    @(posedge clk);
    sts <= 1'b1;
    settle;
    access(1'b0, OFF_EVENT_FLAGS, '0);
    check(rd, 32'h1);
    access(1'b1, OFF_EVENT_FLAGS, 32'hF);
    @(posedge clk);
    crst <= 1'b1;
    settle;
    @(posedge clk);
    crst <= 1'b0;
    settle;
    access(1'b0, OFF_EVENT_FLAGS, '0);
    check(rd, 32'h7);
    access(1'b1, OFF_EVENT_FLAGS, 32'hF);
    @(posedge clk);
    sts <= 1'b0;
    settle;
    access(1'b0, OFF_EVENT_FLAGS, '0);
    check(rd, 32'h0);
    access(1'b1, OFF_CONTROL, 32'hA5A5_5A5A);
    access(1'b1, OFF_POWER_CTRL, 32'h5A5A_A5A5);
    access(1'b0, OFF_POWER_CTRL, '0);
    check(rd, 32'h5A5A_A5A5);
    check(pwc, 32'h5A5A_A5A5);
    check(ctl, 32'hA5A5_5A5A);
    access(1'b0, 12'h014, '0);
    check(rd, '0);
    give_verdict;
  end
endmodule
`default_nettype wire
